// file: pkg/bft_regs.svh
// Register map, fields, reset values and timing
`ifndef BFT_REGS_SVH
`define BFT_REGS_SVH

// Byte offsets of the APB registers
`define BFT_OFF_CTRL      8'h00
`define BFT_OFF_PHASE_THR 8'h04
`define BFT_OFF_RES_THR   8'h08
`define BFT_OFF_RT_DELAY  8'h0C
`define BFT_OFF_BF_DELAY  8'h10
`define BFT_OFF_STATUS    8'h14
`define BFT_OFF_RT_COUNT  8'h18
`define BFT_OFF_BF_COUNT  8'h1C

// Control register fields
`define BFT_CTRL_MODE_LSB   0
`define BFT_CTRL_MODE_MSB   3
`define BFT_CTRL_RETRIP_BIT 4
`define BFT_CTRL_RES_LSB    5
`define BFT_CTRL_RES_MSB    6

// Status register fields
`define BFT_STAT_COND_LSB 0
`define BFT_STAT_COND_MSB 2
`define BFT_STAT_CUR_BIT  3
`define BFT_STAT_TRIP_BIT 4
`define BFT_STAT_BLK_BIT  5

// Reset values: current only, retrip on, no residual input
`define BFT_CTRL_RST      7'h10
`define BFT_PHASE_THR_RST 16'h0014
`define BFT_RES_THR_RST   16'h04B0
`define BFT_RT_DELAY_RST  19'h00014
`define BFT_BF_DELAY_RST  19'h00028

// Release ratio in percent of threshold
`define BFT_RELEASE_PCT 97
`define BFT_FULL_PCT    100

// Program cycle, equal to one delay step
`define BFT_CYCLE_US 5000
`define BFT_CLK_MHZ  50
`define BFT_CYCLE_CLKS (`BFT_CYCLE_US * `BFT_CLK_MHZ)

`endif

// file: pkg/bft_pkg.sv
// Types shared by the timer modules
package bft_pkg;

   typedef enum logic [3:0] {
      BFT_MODE_CUR          = 4'h0,
      BFT_MODE_DO           = 4'h1,
      BFT_MODE_SIG          = 4'h2,
      BFT_MODE_CUR_AND_DO   = 4'h3,
      BFT_MODE_CUR_AND_SIG  = 4'h4,
      BFT_MODE_CUR_OR_SIG   = 4'h5,
      BFT_MODE_SIG_AND_DO   = 4'h6,
      BFT_MODE_SIG_OR_DO    = 4'h7,
      BFT_MODE_CUR_OR_DO    = 4'h8,
      BFT_MODE_ANY          = 4'h9,
      BFT_MODE_ALL          = 4'hA
   } bft_mode_e;

   typedef enum logic [2:0] {
      BFT_COND_NORMAL  = 3'h0,
      BFT_COND_START   = 3'h1,
      BFT_COND_RETRIP  = 3'h2,
      BFT_COND_BF_ON   = 3'h3,
      BFT_COND_BLOCKED = 3'h4
   } bft_cond_e;

   typedef enum logic [2:0] {
      BFT_ST_NORMAL  = 3'b001,
      BFT_ST_STARTED = 3'b010,
      BFT_ST_BLOCKED = 3'b100
   } bft_state_e;

endpackage

// file: pkg/bft_pick_if.sv
// Timer core to pick-up comparator signals
`timescale 1ns/100ps
`default_nettype none
interface bft_pick_if #(parameter int W = 16);
   logic [2:0][W-1:0] phase_mag;
   logic [W-1:0]      res_mag;
   logic              res_en;
   logic [W-1:0]      phase_thr;
   logic [W-1:0]      res_thr;
   logic              tick;
   logic              cur_pickup;

   modport core (output phase_mag, res_mag, res_en, phase_thr, res_thr, tick,
                 input cur_pickup);
   modport cmp  (input phase_mag, res_mag, res_en, phase_thr, res_thr, tick,
                 output cur_pickup);
endinterface
`default_nettype wire

// file: core/bft_pickup.sv
// Current pick-up comparator with fixed release ratio per channel
`timescale 1ns/100ps
`default_nettype none
`include "bft_regs.svh"
module bft_pickup
   import bft_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic pclk,
   input  wire logic presetn,
   bft_pick_if.cmp   pk
);
   localparam int PW = W + 7;

   logic [3:0] act;
   logic [3:0] next_act;

   // Channels 0..2 phases, 3 the residual
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         logic [W-1:0]  mag;
         logic [W-1:0]  thr;
         logic          en;
         logic [PW-1:0] mag_s;
         logic [PW-1:0] rel_s;
         assign mag   = (g < 3) ? pk.phase_mag[g % 3] : pk.res_mag;
         assign thr   = (g < 3) ? pk.phase_thr : pk.res_thr;
         assign en    = (g < 3) ? 1'b1 : pk.res_en;
         assign mag_s = PW'(mag) * PW'(`BFT_FULL_PCT);
         assign rel_s = PW'(thr) * PW'(`BFT_RELEASE_PCT);
         // Hysteresis keeps a marginal current from chattering the timers
         always_comb begin
            next_act[g] = act[g];
            if (!en) begin
               next_act[g] = 1'b0;
            end else if (pk.tick) begin
               if (mag > thr) begin
                  next_act[g] = 1'b1;
               end else if (mag_s < rel_s) begin
                  next_act[g] = 1'b0;
               end
            end
         end
      end
   endgenerate

   // Flags set and release on program cycle ticks; a disabled residual flag clears at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act <= 4'h0;
      end else begin
         act <= next_act;
      end
   end

   assign pk.cur_pickup = |act;
endmodule
`default_nettype wire

// file: core/bft_timer.sv
// Breaker failure timer core with APB register file
//
// Summary of operation
// - Blocking input sampled at each program cycle start
// - Unblocked pick-up asserts start, runs both timers
// - Blocked pick-up asserts blocked, no timing follows
// - Blocking during start moves it to blocked, clearing the timers
// - One pick-up starts both delay counters together
// - Retrip enable setting removes retrip path when off
// - Retrip output after retrip delay of start
// - Breaker failure output after its delay of start
// - Readable condition: normal, start, retrip, failure, blocked
// - Current only mode: current starts, drop resets
// - And mode: hold until trip, reset on either
// - And mode: timing begins once trip output asserts
// - Or mode: either starts, both released resets
// - Or mode: outputs fire when either held long
// - Retrip off leaves one failure counter, same modes
// - Single counter in current mode resets immediately
// - Pick-up above threshold, release at 97 percent
// - Mode selects current, signal, output or combinations
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "bft_regs.svh"
module bft_timer
   import bft_pkg::*;
#(
   parameter int W          = 16,
   parameter int DW         = 19,
   parameter int CYCLE_CLKS = `BFT_CYCLE_CLKS
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic [2:0][W-1:0] phase_mag,
   input  wire logic [2:0][W-1:0] residual_mag,
   input  wire logic            trip_monitor,
   input  wire logic            signal_monitor,
   input  wire logic            block_in,
   output logic                 start_out,
   output logic                 blocked_out,
   output logic                 redundant_trip_out,
   output logic                 breaker_failure_output
);
   localparam int CW = $clog2(CYCLE_CLKS + 1);
   localparam logic [CW-1:0] CYC_LAST = CW'(CYCLE_CLKS - 1);

   // Configuration registers
   logic [6:0]    ctrl;
   logic [W-1:0]  phase_pickup_threshold;
   logic [W-1:0]  residual_pickup_threshold;
   logic [DW-1:0] redundant_trip_delay_setting;
   logic [DW-1:0] bf_delay;
   logic [6:0]    next_ctrl;
   logic [W-1:0]  next_phase_thr;
   logic [W-1:0]  next_res_thr;
   logic [DW-1:0] next_rt_delay;
   logic [DW-1:0] next_bf_delay;

   // Bus answer
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [31:0] rd_val;
   logic        mapped;
   logic        wr_en;

   // Program cycle and timing state
   logic [CW-1:0] cyc_cnt;
   logic [CW-1:0] next_cyc_cnt;
   logic          tick;
   logic          next_tick;
   bft_state_e    state;
   bft_state_e    next_state;
   logic [DW-1:0] rt_cnt;
   logic [DW-1:0] bf_cnt;
   logic [DW-1:0] next_rt_cnt;
   logic [DW-1:0] next_bf_cnt;
   logic          block_smp;
   logic          next_block_smp;
   logic          next_start;
   logic          next_blocked;
   logic          next_rt_out;
   logic          next_bf_out;

   bft_mode_e mode;
   logic      retrip_en;
   logic      cur_pk;
   logic      pick;
   bft_cond_e cond;

   bft_pick_if #(.W(W)) pk_if ();

   assign retrip_en = ctrl[`BFT_CTRL_RETRIP_BIT];
   assign mode      = bft_mode_e'(ctrl[`BFT_CTRL_MODE_MSB:`BFT_CTRL_MODE_LSB]);

   // Residual source: 0 off, else input sel minus one
   assign pk_if.phase_mag = phase_mag;
   assign pk_if.res_en    = |ctrl[`BFT_CTRL_RES_MSB:`BFT_CTRL_RES_LSB];
   assign pk_if.res_mag   = pk_if.res_en ?
      residual_mag[ctrl[`BFT_CTRL_RES_MSB:`BFT_CTRL_RES_LSB] - 2'h1] : '0;
   assign pk_if.phase_thr = phase_pickup_threshold;
   assign pk_if.res_thr   = residual_pickup_threshold;
   assign pk_if.tick      = tick;
   assign cur_pk          = pk_if.cur_pickup;

   bft_pickup #(.W(W)) u_pickup (
      .pclk    (pclk),
      .presetn (presetn),
      .pk      (pk_if)
   );

   // Mode decides which conditions form the pick-up
   always_comb begin
      unique case (mode)
         BFT_MODE_CUR:         pick = cur_pk;
         BFT_MODE_DO:          pick = trip_monitor;
         BFT_MODE_SIG:         pick = signal_monitor;
         BFT_MODE_CUR_AND_DO:  pick = cur_pk & trip_monitor;
         BFT_MODE_CUR_AND_SIG: pick = cur_pk & signal_monitor;
         BFT_MODE_CUR_OR_SIG:  pick = cur_pk | signal_monitor;
         BFT_MODE_SIG_AND_DO:  pick = signal_monitor & trip_monitor;
         BFT_MODE_SIG_OR_DO:   pick = signal_monitor | trip_monitor;
         BFT_MODE_CUR_OR_DO:   pick = cur_pk | trip_monitor;
         BFT_MODE_ANY:         pick = cur_pk | signal_monitor | trip_monitor;
         BFT_MODE_ALL:         pick = cur_pk & signal_monitor & trip_monitor;
         default:              pick = cur_pk; // Unused codes act as current only
      endcase
   end

   // Program cycle divider; one tick is one delay step
   always_comb begin
      next_cyc_cnt = cyc_cnt + CW'(1);
      next_tick    = 1'b0;
      if (cyc_cnt == CYC_LAST) begin
         next_cyc_cnt = '0;
         next_tick    = 1'b1;
      end
   end

   // Timing state machine, evaluated once per program cycle
   always_comb begin
      next_state     = state;
      next_rt_cnt    = rt_cnt;
      next_bf_cnt    = bf_cnt;
      next_block_smp = block_smp;
      if (tick) begin
         next_block_smp = block_in;
         unique case (state)
            BFT_ST_NORMAL: begin
               if (pick && block_in) begin
                  next_state = BFT_ST_BLOCKED;
               end else if (pick) begin
                  next_state = BFT_ST_STARTED;
               end
            end
            BFT_ST_STARTED: begin
               if (!pick) begin
                  next_state = BFT_ST_NORMAL;
               end else if (block_in) begin
                  next_state = BFT_ST_BLOCKED;
               end
            end
            BFT_ST_BLOCKED: begin
               if (!pick) begin
                  next_state = BFT_ST_NORMAL;
               end
            end
         endcase
         // Both counters share the pick-up; each steps until it reaches its own delay
         if (state == BFT_ST_STARTED && next_state == BFT_ST_STARTED) begin
            if (bf_cnt < bf_delay) begin
               next_bf_cnt = bf_cnt + DW'(1);
            end
            if (retrip_en && rt_cnt < redundant_trip_delay_setting) begin
               next_rt_cnt = rt_cnt + DW'(1);
            end
         end else begin
            next_rt_cnt = '0;
            next_bf_cnt = '0;
         end
         if (!retrip_en) begin
            next_rt_cnt = '0;
         end
      end
   end

   // Outputs follow the next state so they switch on the tick edge
   always_comb begin
      next_start   = (next_state == BFT_ST_STARTED);
      next_blocked = (next_state == BFT_ST_BLOCKED);
      next_rt_out  = next_start && retrip_en &&
                     (next_rt_cnt >= redundant_trip_delay_setting);
      next_bf_out  = next_start && (next_bf_cnt >= bf_delay);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_cnt                <= '0;
         tick                   <= 1'b0;
         state                  <= BFT_ST_NORMAL;
         rt_cnt                 <= '0;
         bf_cnt                 <= '0;
         block_smp              <= 1'b0;
         start_out              <= 1'b0;
         blocked_out            <= 1'b0;
         redundant_trip_out     <= 1'b0;
         breaker_failure_output <= 1'b0;
      end else begin
         cyc_cnt                <= next_cyc_cnt;
         tick                   <= next_tick;
         state                  <= next_state;
         rt_cnt                 <= next_rt_cnt;
         bf_cnt                 <= next_bf_cnt;
         block_smp              <= next_block_smp;
         start_out              <= next_start;
         blocked_out            <= next_blocked;
         redundant_trip_out     <= next_rt_out;
         breaker_failure_output <= next_bf_out;
      end
   end

   // Condition code; failure outranks retrip, which outranks start
   always_comb begin
      if (breaker_failure_output) begin
         cond = BFT_COND_BF_ON;
      end else if (redundant_trip_out) begin
         cond = BFT_COND_RETRIP;
      end else if (start_out) begin
         cond = BFT_COND_START;
      end else if (blocked_out) begin
         cond = BFT_COND_BLOCKED;
      end else begin
         cond = BFT_COND_NORMAL;
      end
   end

   // Read decode; unmapped offsets answer with an error and zero data
   always_comb begin
      rd_val = '0;
      mapped = 1'b1;
      unique case (paddr)
         `BFT_OFF_CTRL:      rd_val[6:0]    = ctrl;
         `BFT_OFF_PHASE_THR: rd_val[W-1:0]  = phase_pickup_threshold;
         `BFT_OFF_RES_THR:   rd_val[W-1:0]  = residual_pickup_threshold;
         `BFT_OFF_RT_DELAY:  rd_val[DW-1:0] = redundant_trip_delay_setting;
         `BFT_OFF_BF_DELAY:  rd_val[DW-1:0] = bf_delay;
         `BFT_OFF_STATUS: begin
            rd_val[`BFT_STAT_COND_MSB:`BFT_STAT_COND_LSB] = cond;
            rd_val[`BFT_STAT_CUR_BIT]  = cur_pk;
            rd_val[`BFT_STAT_TRIP_BIT] = trip_monitor;
            rd_val[`BFT_STAT_BLK_BIT]  = block_smp;
         end
         `BFT_OFF_RT_COUNT:  rd_val[DW-1:0] = rt_cnt;
         `BFT_OFF_BF_COUNT:  rd_val[DW-1:0] = bf_cnt;
         default:            mapped = 1'b0;
      endcase
   end

   // One wait state; the write lands on the edge that sees pready high
   always_comb begin
      next_pready  = psel && penable && !pready;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      if (next_pready) begin
         next_prdata  = (pwrite || !mapped) ? 32'h0000_0000 : rd_val;
         next_pslverr = !mapped;
      end
      wr_en          = psel && penable && pready && pwrite;
      next_ctrl      = ctrl;
      next_phase_thr = phase_pickup_threshold;
      next_res_thr   = residual_pickup_threshold;
      next_rt_delay  = redundant_trip_delay_setting;
      next_bf_delay  = bf_delay;
      if (wr_en) begin
         unique case (paddr)
            `BFT_OFF_CTRL:      next_ctrl      = pwdata[6:0];
            `BFT_OFF_PHASE_THR: next_phase_thr = pwdata[W-1:0];
            `BFT_OFF_RES_THR:   next_res_thr   = pwdata[W-1:0];
            `BFT_OFF_RT_DELAY:  next_rt_delay  = pwdata[DW-1:0];
            `BFT_OFF_BF_DELAY:  next_bf_delay  = pwdata[DW-1:0];
            default:            next_ctrl      = ctrl; // Read-only or unmapped
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready                       <= 1'b0;
         prdata                       <= 32'h0000_0000;
         pslverr                      <= 1'b0;
         ctrl                         <= `BFT_CTRL_RST;
         phase_pickup_threshold       <= `BFT_PHASE_THR_RST;
         residual_pickup_threshold    <= `BFT_RES_THR_RST;
         redundant_trip_delay_setting <= `BFT_RT_DELAY_RST;
         bf_delay                     <= `BFT_BF_DELAY_RST;
      end else begin
         pready                       <= next_pready;
         prdata                       <= next_prdata;
         pslverr                      <= next_pslverr;
         ctrl                         <= next_ctrl;
         phase_pickup_threshold       <= next_phase_thr;
         residual_pickup_threshold    <= next_res_thr;
         redundant_trip_delay_setting <= next_rt_delay;
         bf_delay                     <= next_bf_delay;
      end
   end
endmodule
`default_nettype wire

// file: test/bft_timer_assertions.sv
// Port checker for the timer
`timescale 1ns/100ps
`default_nettype none
module bft_chk
#(
   parameter int CYCLE_CLKS = 8
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic psel,
   input  wire logic penable,
   input  wire logic pready,
   input  wire logic pslverr,
   input  wire logic start_out,
   input  wire logic blocked_out,
   input  wire logic redundant_trip_out,
   input  wire logic breaker_failure_output
);
   logic [31:0] since_chg;
   logic [31:0] next_since_chg;
   logic [1:0]  last_flags;
   logic        flags_moved;

   // Clocks since start or blocked last moved
   assign flags_moved = ({start_out, blocked_out} != last_flags);
   always_comb begin
      next_since_chg = flags_moved ? 32'h0 : since_chg + 32'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_chg  <= 32'h0;
         last_flags <= 2'b00;
      end else begin
         since_chg  <= next_since_chg;
         last_flags <= {start_out, blocked_out};
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_blk_excl; blocked_out |-> !start_out; endproperty
   a_blk_excl: assert property (p_blk_excl)
      else $error("blocked and start high together");
   property p_rt_in_start; redundant_trip_out |-> start_out; endproperty
   a_rt_in_start: assert property (p_rt_in_start)
      else $error("retrip high without start");
   property p_bf_in_start; breaker_failure_output |-> start_out; endproperty
   a_bf_in_start: assert property (p_bf_in_start)
      else $error("failure high without start");
   property p_tick_gap; flags_moved |-> since_chg >= 32'(CYCLE_CLKS - 1); endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("start or blocked moved between ticks");
   property p_rt_hold; $fell(redundant_trip_out) |-> !start_out; endproperty
   a_rt_hold: assert property (p_rt_hold)
      else $error("retrip dropped while started");
   property p_bf_hold; $fell(breaker_failure_output) |-> !start_out; endproperty
   a_bf_hold: assert property (p_bf_hold)
      else $error("failure dropped while started");
   property p_answer; psel && penable && !pready |=> pready; endproperty
   a_answer: assert property (p_answer)
      else $error("register answer late");
   property p_pulse; pready |=> !pready ##1 !pready; endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready longer than one cycle");
   property p_err; pslverr |-> pready && psel && penable; endproperty
   a_err: assert property (p_err)
      else $error("error outside an answer");

   c_start: cover property ($rose(start_out));
   c_rt: cover property ($rose(redundant_trip_out));
   c_bf: cover property ($rose(breaker_failure_output));
   c_blk: cover property ($rose(blocked_out));
endmodule

bind bft_timer bft_chk #(.CYCLE_CLKS(CYCLE_CLKS)) i_chk (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .start_out, .blocked_out, .redundant_trip_out, .breaker_failure_output);
`default_nettype wire

// file: test/bft_breaker_model.sv
// Feeder breaker with redundant coil, plus upstream breaker
`timescale 1ns/100ps
`default_nettype none
module bft_breaker_model #(
   parameter int OP_CLKS = 12
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        primary_trip,
   input  wire logic        redundant_trip_out,
   input  wire logic        breaker_failure_output,
   input  wire logic [15:0] fault_level,
   input  wire logic        stuck,
   input  wire logic        retrip_ok,
   input  wire logic        reclose,
   output logic [2:0][15:0] phase_mag,
   output logic             trip_monitor
);
   logic       closed;
   logic [7:0] op_cnt;
   logic       cmd;

   // A stuck mechanism ignores only the primary coil
   assign cmd = (primary_trip && !stuck) || (redundant_trip_out && retrip_ok)
                || breaker_failure_output;
   assign phase_mag = {16'h0000, 16'h0000, closed ? fault_level : 16'h0000};
   assign trip_monitor = primary_trip;

   // Contacts part after the operating time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         closed <= 1'b1;
         op_cnt <= 8'h00;
      end else if (reclose || !cmd) begin
         closed <= closed | reclose;
         op_cnt <= 8'h00;
      end else if (closed) begin
         op_cnt <= op_cnt + 8'h01;
         if (op_cnt == 8'(OP_CLKS - 1)) begin
            closed <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/bft_timer_test.sv
// Self-checking bench for the breaker failure timer
`timescale 1ns/100ps
`default_nettype none
`include "bft_regs.svh"
`define BFT_CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module bft_timer_test
   import bft_pkg::*;
;
   localparam int CYC = 8;
   localparam int DRT = 3;
   localparam int DBF = 8;
   localparam logic [7:0] PICK [12] = '{8'hF0, 8'hAA, 8'hCC, 8'hA0, 8'hC0, 8'hFC,
                                         8'h88, 8'hEE, 8'hFA, 8'hFE, 8'h80, 8'hF0};
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [2:0][15:0] phase_mag, residual_mag;
   logic             trip_monitor, signal_monitor, block_in;
   logic             start_out, blocked_out, redundant_trip_out, breaker_failure_output;
   logic             primary_trip, stuck, retrip_ok, reclose;
   logic [15:0]      fault_level;
   wire logic [3:0]  outs;
   int               error_cnt, checked;

   assign outs = {blocked_out, breaker_failure_output, redundant_trip_out, start_out};

   bft_timer #(.CYCLE_CLKS(CYC)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .phase_mag, .residual_mag, .trip_monitor,
      .signal_monitor, .block_in, .start_out, .blocked_out, .redundant_trip_out,
      .breaker_failure_output);
   bft_breaker_model i_brk (.pclk, .presetn, .primary_trip, .redundant_trip_out,
      .breaker_failure_output, .fault_level, .stuck, .retrip_ok, .reclose, .phase_mag,
      .trip_monitor);

   // Free-running 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic timeout();
      error_cnt++;
      give_verdict();
   endtask

   // One APB transfer; data taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) timeout();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wait_ticks(input int t);
      repeat (t * CYC) @(posedge pclk);
   endtask

   task automatic wait_hi(input int i, output int n);
      n = 0;
      while (outs[i] !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (outs[i] !== 1'b1) timeout();
   endtask

   // Clear all causes, reclose, expect a quiet block
   task automatic idle();
      primary_trip <= 1'b0; fault_level <= 16'h0; block_in <= 1'b0; signal_monitor <= 1'b0;
      reclose <= 1'b1;
      @(posedge pclk);
      reclose <= 1'b0;
      wait_ticks(3);
      `BFT_CHK(outs, 4'h0);
   endtask

   task automatic s_defaults();
      apb(1'b0, `BFT_OFF_CTRL, 32'h0); `BFT_CHK(rd[6:0], 7'h10);
      apb(1'b0, `BFT_OFF_RT_DELAY, 32'h0); `BFT_CHK(rd[18:0], 19'h00014);
      apb(1'b0, `BFT_OFF_BF_DELAY, 32'h0); `BFT_CHK(rd[18:0], 19'h00028);
      apb(1'b0, 8'h20, 32'h0); `BFT_CHK(err, 1'b1);
      apb(1'b0, `BFT_OFF_STATUS, 32'h0); `BFT_CHK(rd[2:0], BFT_COND_NORMAL);
      // Retrip plus margins stays below failure delay
      apb(1'b1, `BFT_OFF_RT_DELAY, DRT);
      apb(1'b1, `BFT_OFF_BF_DELAY, DBF);
   endtask

   // Stuck breaker, current only: both delays from one start
   task automatic s_cur_only();
      int n, m;
      stuck <= 1'b1; retrip_ok <= 1'b0; fault_level <= 16'h0014;
      wait_ticks(3);
      `BFT_CHK(start_out, 1'b0);
      fault_level <= 16'h0015;
      wait_hi(0, n);
      wait_hi(1, n); `BFT_CHK(n, DRT*CYC);
      wait_hi(2, m); `BFT_CHK(n + m, DBF*CYC);
      apb(1'b0, `BFT_OFF_STATUS, 32'h0); `BFT_CHK(rd[2:0], BFT_COND_BF_ON);
      wait_ticks(3);
      `BFT_CHK(outs, 4'h0);
      apb(1'b0, `BFT_OFF_BF_COUNT, 32'h0); `BFT_CHK(rd[18:0], 19'h0);
      idle();
   endtask

   task automatic s_release();
      int n;
      fault_level <= 16'h0015;
      wait_hi(0, n);
      fault_level <= 16'h0014;
      wait_ticks(2);
      `BFT_CHK(start_out, 1'b1);
      fault_level <= 16'h0013;
      wait_ticks(2);
      `BFT_CHK(start_out, 1'b0);
      apb(1'b1, `BFT_OFF_CTRL, 32'h50);
      residual_mag[1] <= 16'h04B1;
      wait_hi(0, n);
      residual_mag[1] <= '0;
      idle();
   endtask

   // Current and trip: held until trip, retrip clears
   task automatic s_and();
      int n;
      apb(1'b1, `BFT_OFF_CTRL, 32'h13);
      retrip_ok <= 1'b1; fault_level <= 16'h0100;
      wait_ticks(3);
      `BFT_CHK(start_out, 1'b0);
      apb(1'b0, `BFT_OFF_RT_COUNT, 32'h0); `BFT_CHK(rd[18:0], 19'h0);
      primary_trip <= 1'b1;
      wait_hi(0, n);
      wait_hi(1, n); `BFT_CHK(n, DRT*CYC);
      apb(1'b0, `BFT_OFF_STATUS, 32'h0); `BFT_CHK(rd[2:0], BFT_COND_RETRIP);
      wait_ticks(DBF);
      `BFT_CHK(outs, 4'h0);
      idle();
   endtask

   // Current or trip: trip alone runs both
   task automatic s_or();
      int n;
      apb(1'b1, `BFT_OFF_CTRL, 32'h18);
      retrip_ok <= 1'b0; primary_trip <= 1'b1;
      wait_hi(0, n);
      wait_hi(2, n); `BFT_CHK(n, DBF*CYC);
      wait_ticks(2);
      `BFT_CHK(outs, 4'h7);
      primary_trip <= 1'b0;
      wait_ticks(2);
      `BFT_CHK(outs, 4'h0);
      idle();
   endtask

   task automatic s_block();
      int n;
      apb(1'b1, `BFT_OFF_CTRL, 32'h10);
      block_in <= 1'b1;
      wait_ticks(1);
      fault_level <= 16'h0100;
      wait_hi(3, n);
      apb(1'b0, `BFT_OFF_STATUS, 32'h0); `BFT_CHK(rd[2:0], BFT_COND_BLOCKED);
      wait_ticks(DRT + 1);
      `BFT_CHK(outs, 4'h8);
      idle();
      fault_level <= 16'h0100;
      wait_hi(0, n);
      block_in <= 1'b1;
      wait_hi(3, n);
      `BFT_CHK(outs, 4'h8);
      apb(1'b0, `BFT_OFF_RT_COUNT, 32'h0); `BFT_CHK(rd[18:0], 19'h0);
      idle();
   endtask

   // Retrip off: one failure counter
   task automatic s_single();
      int n;
      apb(1'b1, `BFT_OFF_CTRL, 32'h00);
      retrip_ok <= 1'b1; fault_level <= 16'h0100;
      wait_hi(0, n);
      wait_hi(2, n); `BFT_CHK(n, DBF*CYC);
      `BFT_CHK(redundant_trip_out, 1'b0);
      apb(1'b0, `BFT_OFF_RT_COUNT, 32'h0); `BFT_CHK(rd[18:0], 19'h0);
      wait_ticks(3);
      `BFT_CHK(outs, 4'h0);
      idle();
   endtask

   // Each mode, one unused code too, against each input mix except all inputs off
   task automatic s_modes();
      for (int m = 0; m < 12; m++) begin
         apb(1'b1, `BFT_OFF_CTRL, 32'h10 | 32'(m));
         for (int c = 1; c < 8; c++) begin
            fault_level <= c[2] ? 16'h0100 : 16'h0000;
            signal_monitor <= c[1];
            primary_trip <= c[0];
            wait_ticks(3);
            `BFT_CHK(start_out, PICK[m][c]);
            idle();
         end
      end
   endtask

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, residual_mag} = '0;
      {signal_monitor, block_in, primary_trip, retrip_ok, reclose, fault_level} = '0;
      stuck = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_defaults();
      s_cur_only();
      s_release();
      s_and();
      s_or();
      s_block();
      s_single();
      s_modes();
      give_verdict();
   end
endmodule
`default_nettype wire
